// *** core/dasu_consts.svh ***
`ifndef DASU_CONSTS_SVH
`define DASU_CONSTS_SVH

// Operation codes
`define DASU_ACCUM_DECIMAL_ADD_OP 6'h36
`define DASU_ACCUM_DECIMAL_SUB_OP 6'h38
`define DASU_MEMORY_DECIMAL_ADD_OP 6'h2e
`define DASU_MEMORY_DECIMAL_SUB_OP 6'h32
// Unassigned codes, never started
`define DASU_UNASSIGNED_A 6'h00
`define DASU_UNASSIGNED_B 6'h02
`define DASU_UNASSIGNED_C 6'h04
`define DASU_UNASSIGNED_D 6'h06
`define DASU_UNASSIGNED_E 6'h1e

// Field geometry
`define DASU_MAX_DIGITS 5'h10
`define DASU_MIN_DIGITS 5'h01
`define DASU_ZONE_MINUS 2'h2
`define DASU_ZONE_PLUS 2'h0
`define DASU_XS3_BIAS 4'h3
`define DASU_BLANK_CODE 4'h0
`define DASU_DIGIT_MAX 4'h9
`define DASU_RADIX 5'h0a

// Timing in half time units; time unit and clock period in ns
`define DASU_BASE_HALF 11'h063
`define DASU_STEP_HALF 11'h01b
`define DASU_RCAD_HALF 11'h036
`define DASU_RCAM_HALF 11'h03f
`define DASU_TIME_UNIT_NS 32'h0000_03e8
`define DASU_CLK_PERIOD_NS 32'h0000_0005
`define DASU_HALF_UNIT_CYC \
	(`DASU_TIME_UNIT_NS / (32'h0000_0002 * `DASU_CLK_PERIOD_NS))

`endif

// *** core/dasu_core.sv ***
`timescale 1ns/1ps
`include "dasu_consts.svh"
// Contract
// - Add decimal adds L memory digits into the accumulator.
// - Short accumulator widens to L; new sentinel unless length 16.
// - Carry stops below sentinel; carry into it sets overflow flag.
// - Zones ignored; zero is plus except minus zero plus minus zero. The code also gives minus zero when two minus operands overflow.
// - Subtract decimal takes L digits from accumulator, result there.
// - Subtract decimal shares all length, carry, overflow handling.
// - Add ops set zero flag on zero sum, minus on negative.
// - Subtract ops set zero and minus flags from the difference.
// - Add to memory adds accumulator to L digits, sum to memory.
// - Accumulator digits above L are ignored for memory ops.
// - Missing accumulator digits read as zero, accumulator untouched.
// - Memory ops leave accumulator, sentinel and sign unchanged.
// - Carry out of top memory digit sets overflow flag.
// - Subtract from memory is add to memory, accumulator sign inverted.
// - Add decimal lasts 49.5+13.5(L+Lc), or 49.5+27Lm recomplementing.
// - Subtract decimal times as add; recomplement on larger memory.
// - Add to memory lasts 49.5+13.5L, or 49.5+31.5L recomplementing.
// - Subtract from memory times likewise with equal signs.
// - Codes 00, 02, 04, 06, 1e start nothing.
module dasu_core import dasu_pkg::*; #(
	parameter int HALF_UNIT_CYCLES = `DASU_HALF_UNIT_CYC
) (
	input wire logic CLK, // Clock
	input wire logic RST, // Async reset, high
	input wire logic OP_START, // Start pulse
	input wire logic [5:0] OP_CODE, // Operation code
	input wire logic [14:0] OP_ADDR, // Address of memory LSD
	input wire logic [4:0] OP_LEN, // L, 1 to 16
	input wire logic [63:0] SEL_ACC_DIGITS_IN, // Accumulator digits
	input wire logic [4:0] SEL_ACC_LEN_IN, // Accumulator length
	input wire logic SEL_ACC_SIGN_IN, // Accumulator minus
	input wire logic [5:0] MEM_RDATA, // Read char, cycle after read
	input wire logic OVF_CLR, // Clear overflow flag
	output logic BUSY, // Operation running
	output logic DONE, // Completion pulse
	output logic ILLEGAL_OP, // Unassigned code pulse
	output logic MEM_RD, // Memory read strobe
	output logic MEM_WR, // Memory write strobe
	output logic [14:0] MEM_ADDR, // Memory address
	output logic [5:0] MEM_WDATA, // Memory write char
	output logic SEL_ACC_WE, // Accumulator write pulse
	output logic [63:0] SEL_ACC_DIGITS, // New digits
	output logic [4:0] SEL_ACC_LEN, // New length, 16 no sentinel
	output logic SEL_ACC_SIGN, // New sign
	output logic ZERO_RESULT_FLAG, // Zero result
	output logic MINUS_RESULT_FLAG, // Negative result
	output logic DECIMAL_OVERFLOW_FLAG // Sticky overflow
);
	dasu_state_e state_reg;
	dasu_digit_t x_reg [0:15];
	dasu_digit_t y_reg [0:15];
	dasu_digit_t acc_dig [0:15];
	logic [63:0] x_flat;
	logic [4:0] len_reg, n_reg, idx_reg, lc_reg;
	logic [14:0] addr_reg;
	logic [17:0] elapsed_reg;
	logic op_mem_reg, sx_reg, sy_reg, carry_reg, nz_reg;
	logic ovf_reg, recomp_reg, rsign_reg;
	logic busy_reg, done_reg, ill_reg, rd_reg, wr_reg, we_reg;
	logic [14:0] maddr_reg;
	logic [5:0] wdata_reg;
	logic [63:0] acc_out_reg;
	logic [4:0] acc_len_reg;
	logic acc_sign_reg, zero_reg, minus_reg, ovf_flag_reg, ovf_flag_next;

	// Decode, used at start and by checks
	function automatic logic is_unassigned(input logic [5:0] c);
		return c == `DASU_UNASSIGNED_A || c == `DASU_UNASSIGNED_B ||
			c == `DASU_UNASSIGNED_C || c == `DASU_UNASSIGNED_D ||
			c == `DASU_UNASSIGNED_E;
	endfunction

	// Excess-three char to digit; blank-like codes count as zero
	function automatic dasu_digit_t char_digit(input dasu_char_t c);
		return (c[3:0] == `DASU_BLANK_CODE) ? 4'h0 :
			4'(c[3:0] - `DASU_XS3_BIAS);
	endfunction

	wire op_ad = OP_CODE == `DASU_ACCUM_DECIMAL_ADD_OP;
	wire op_sd = OP_CODE == `DASU_ACCUM_DECIMAL_SUB_OP;
	wire op_am = OP_CODE == `DASU_MEMORY_DECIMAL_ADD_OP;
	wire op_sm = OP_CODE == `DASU_MEMORY_DECIMAL_SUB_OP;
	wire len_ok = OP_LEN >= `DASU_MIN_DIGITS && OP_LEN <= `DASU_MAX_DIGITS;
	wire unassigned = is_unassigned(OP_CODE);
	wire accept = OP_START && !busy_reg && len_ok &&
		(op_ad || op_sd || op_am || op_sm);
	wire start_mem = op_am || op_sm;
	// Subtract ops invert the subtrahend sign and reuse the add path
	wire start_sx = start_mem ? 1'b0 : SEL_ACC_SIGN_IN;
	wire start_sy = start_mem ? (SEL_ACC_SIGN_IN ^ op_sm) : op_sd;
	wire [4:0] start_n = start_mem ? OP_LEN :
		((SEL_ACC_LEN_IN > OP_LEN) ? SEL_ACC_LEN_IN : OP_LEN);

	// Accumulator digits above its own length read as zero
	genvar gi;
	generate
		for (gi = 0; gi < 16; gi++) begin : g_dig
			assign acc_dig[gi] = (5'(gi) < SEL_ACC_LEN_IN) ?
				SEL_ACC_DIGITS_IN[4*gi +: 4] : 4'h0;
			assign x_flat[4*gi +: 4] = x_reg[gi];
		end
	endgenerate

	// Serial datapath; one shared position adder
	wire eff_sub = sx_reg ^ sy_reg;
	wire in_recomp = state_reg == ST_RECOMP;
	wire [3:0] ix = idx_reg[3:0];
	wire last = idx_reg == 5'(n_reg - 5'h01);
	dasu_digit_t add_s;
	logic add_c;
	dasu_digit_adder u_add (
		.a(in_recomp ? 4'h0 : x_reg[ix]),
		.b(in_recomp ? x_reg[ix] : y_reg[ix]),
		.sub(in_recomp || eff_sub),
		.cin(carry_reg),
		.s(add_s),
		.cout(add_c)
	);

	// Duration in half units, then cycles
	wire [10:0] tgt_half = op_mem_reg ?
		(recomp_reg ? 11'(`DASU_BASE_HALF + `DASU_RCAM_HALF * len_reg) :
		11'(`DASU_BASE_HALF + `DASU_STEP_HALF * len_reg)) :
		(recomp_reg ? 11'(`DASU_BASE_HALF + `DASU_RCAD_HALF * n_reg) :
		11'(`DASU_BASE_HALF + `DASU_STEP_HALF * (len_reg + lc_reg)));
	wire [17:0] tgt_cyc = 18'(tgt_half * HALF_UNIT_CYCLES);
	wire finish = state_reg == ST_SETTLE && elapsed_reg >= tgt_cyc;
	// Zero is positive unless it comes from adding two minus operands (minus zeros or overflow)
	wire fin_sign = rsign_reg && (nz_reg || !eff_sub);
	wire [5:0] wr_char = {(idx_reg == 5'h00 && fin_sign) ?
		`DASU_ZONE_MINUS : `DASU_ZONE_PLUS, 4'(x_reg[ix] + `DASU_XS3_BIAS)};

	// Set wins over software clear
	assign ovf_flag_next = (finish && ovf_reg) ||
		(ovf_flag_reg && !OVF_CLR);

	// Digit storage; data only, no reset needed
	always_ff @(posedge CLK) begin
		if (accept) begin
			for (int i = 0; i < 16; i++) begin
				x_reg[i] <= start_mem ? 4'h0 : acc_dig[i];
				y_reg[i] <= start_mem ? acc_dig[i] : 4'h0;
			end
		end else if (state_reg == ST_RD_CAP) begin
			if (op_mem_reg)
				x_reg[ix] <= char_digit(MEM_RDATA);
			else
				y_reg[ix] <= char_digit(MEM_RDATA);
		end else if (state_reg == ST_ADD || in_recomp) begin
			x_reg[ix] <= add_s;
		end
	end

	// Sequencer
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			state_reg <= ST_IDLE;
			idx_reg <= 5'h00;
			{rd_reg, wr_reg, carry_reg, nz_reg, ovf_reg} <= 5'h00;
			{recomp_reg, rsign_reg, op_mem_reg, sx_reg, sy_reg} <= 5'h00;
			{len_reg, n_reg, lc_reg} <= 15'h0000;
			{addr_reg, maddr_reg} <= 30'h0000_0000;
			wdata_reg <= 6'h00;
			elapsed_reg <= 18'h0_0000;
		end else begin
			rd_reg <= 1'b0;
			wr_reg <= 1'b0;
			elapsed_reg <= 18'(elapsed_reg + 18'h0_0001);
			unique case (state_reg)
				ST_IDLE: if (accept) begin
					op_mem_reg <= start_mem;
					sx_reg <= start_sx;
					sy_reg <= start_sy;
					len_reg <= OP_LEN;
					n_reg <= start_n;
					addr_reg <= OP_ADDR;
					maddr_reg <= OP_ADDR;
					rd_reg <= 1'b1;
					{idx_reg, lc_reg} <= 10'h000;
					{nz_reg, ovf_reg, recomp_reg} <= 3'h0;
					elapsed_reg <= 18'h0_0000;
					state_reg <= ST_RD_WAIT;
				end
				ST_RD_WAIT: state_reg <= ST_RD_CAP;
				ST_RD_CAP: begin
					// Sign lives in the zone of the low-order char
					if (idx_reg == 5'h00 && MEM_RDATA[5:4] == `DASU_ZONE_MINUS)
						sx_reg <= !op_mem_reg ? sx_reg : 1'b1;
					if (idx_reg == 5'h00 && !op_mem_reg)
						sy_reg <= sy_reg ^ (MEM_RDATA[5:4] == `DASU_ZONE_MINUS);
					if (idx_reg == 5'(len_reg - 5'h01)) begin
						idx_reg <= 5'h00;
						// One-digit field: its sign lands on this same edge
						carry_reg <= eff_sub ^ (idx_reg == 5'h00 &&
							MEM_RDATA[5:4] == `DASU_ZONE_MINUS);
						state_reg <= ST_ADD;
					end else begin
						idx_reg <= 5'(idx_reg + 5'h01);
						maddr_reg <= 15'(addr_reg - {10'h000, 5'(idx_reg + 5'h01)});
						rd_reg <= 1'b1;
						state_reg <= ST_RD_WAIT;
					end
				end
				ST_ADD: begin
					carry_reg <= add_c;
					nz_reg <= nz_reg || add_s != 4'h0;
					if (!eff_sub && carry_reg && idx_reg >= len_reg)
						lc_reg <= 5'(lc_reg + 5'h01);
					idx_reg <= 5'(idx_reg + 5'h01);
					if (last) begin
						idx_reg <= 5'h00;
						// Carry out of the top position: overflow
						ovf_reg <= !eff_sub && add_c;
						// No end carry on subtract: result is complemented
						recomp_reg <= eff_sub && !add_c;
						rsign_reg <= (eff_sub && !add_c) ? sy_reg : sx_reg;
						carry_reg <= 1'b1;
						state_reg <= (eff_sub && !add_c) ? ST_RECOMP :
							(op_mem_reg ? ST_WR : ST_SETTLE);
					end
				end
				ST_RECOMP: begin
					carry_reg <= add_c;
					idx_reg <= last ? 5'h00 : 5'(idx_reg + 5'h01);
					if (last)
						state_reg <= op_mem_reg ? ST_WR : ST_SETTLE;
				end
				ST_WR: begin
					wr_reg <= 1'b1;
					maddr_reg <= 15'(addr_reg - {10'h000, idx_reg});
					wdata_reg <= wr_char;
					idx_reg <= 5'(idx_reg + 5'h01);
					if (idx_reg == 5'(len_reg - 5'h01))
						state_reg <= ST_SETTLE;
				end
				ST_SETTLE: if (finish)
					state_reg <= ST_IDLE;
			endcase
		end
	end

	// Results and indicators at completion; busy, illegal pulse and overflow clear at any time
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			{busy_reg, done_reg, ill_reg, we_reg} <= 4'h0;
			{zero_reg, minus_reg, ovf_flag_reg, acc_sign_reg} <= 4'h0;
			acc_out_reg <= 64'h0000_0000_0000_0000;
			acc_len_reg <= 5'h00;
		end else begin
			busy_reg <= accept || (busy_reg && !finish);
			done_reg <= finish;
			ill_reg <= OP_START && !busy_reg && unassigned;
			we_reg <= finish && !op_mem_reg;
			ovf_flag_reg <= ovf_flag_next;
			if (finish) begin
				zero_reg <= !nz_reg;
				minus_reg <= fin_sign;
				if (!op_mem_reg) begin
					acc_out_reg <= x_flat;
					acc_len_reg <= n_reg;
					acc_sign_reg <= fin_sign;
				end
			end
		end
	end

	assign BUSY = busy_reg;
	assign DONE = done_reg;
	assign ILLEGAL_OP = ill_reg;
	assign MEM_RD = rd_reg;
	assign MEM_WR = wr_reg;
	assign MEM_ADDR = maddr_reg;
	assign MEM_WDATA = wdata_reg;
	assign SEL_ACC_WE = we_reg;
	assign SEL_ACC_DIGITS = acc_out_reg;
	assign SEL_ACC_LEN = acc_len_reg;
	assign SEL_ACC_SIGN = acc_sign_reg;
	assign ZERO_RESULT_FLAG = zero_reg;
	assign MINUS_RESULT_FLAG = minus_reg;
	assign DECIMAL_OVERFLOW_FLAG = ovf_flag_reg;

	// Checks
	property p_acc_hold;
		@(posedge CLK) disable iff (RST) busy_reg && op_mem_reg |=> !we_reg;
	endproperty
	a_acc_hold: assert property (p_acc_hold)
		else $error("accumulator written by memory op");
	property p_unassigned;
		@(posedge CLK) disable iff (RST)
			OP_START && unassigned && !busy_reg |=> state_reg == ST_IDLE;
	endproperty
	a_unassigned: assert property (p_unassigned)
		else $error("unassigned code started");
	property p_ovf_sticky;
		@(posedge CLK) disable iff (RST)
			ovf_flag_reg && !OVF_CLR |=> ovf_flag_reg;
	endproperty
	a_ovf_sticky: assert property (p_ovf_sticky)
		else $error("overflow flag dropped");
	property p_flags_stable;
		@(posedge CLK) disable iff (RST)
			!finish |=> $stable(zero_reg) && $stable(minus_reg);
	endproperty
	a_flags_stable: assert property (p_flags_stable)
		else $error("flags changed outside completion");
	property p_minus_zero;
		@(posedge CLK) disable iff (RST)
			done_reg && zero_reg && minus_reg |-> !eff_sub && sx_reg;
	endproperty
	a_minus_zero: assert property (p_minus_zero)
		else $error("minus zero from wrong operands");
	property p_serial;
		@(posedge CLK) disable iff (RST) state_reg == ST_ADD && !last
			|=> idx_reg == 5'($past(idx_reg) + 5'h01);
	endproperty
	a_serial: assert property (p_serial)
		else $error("digit step skipped");
	property p_timing;
		@(posedge CLK) disable iff (RST)
			state_reg == ST_SETTLE && elapsed_reg < tgt_cyc |=> !done_reg;
	endproperty
	a_timing: assert property (p_timing)
		else $error("completed early");
	property p_len;
		@(posedge CLK) disable iff (RST) we_reg |-> acc_len_reg >= len_reg;
	endproperty
	a_len: assert property (p_len)
		else $error("result shorter than L");
	property p_ovf_set;
		@(posedge CLK) disable iff (RST) finish && ovf_reg |=> ovf_flag_reg;
	endproperty
	a_ovf_set: assert property (p_ovf_set)
		else $error("overflow not flagged");
	c_recomp: cover property (@(posedge CLK) state_reg == ST_RECOMP);
	c_mem_wr: cover property (@(posedge CLK) wr_reg);
	c_ovf: cover property (@(posedge CLK) finish && ovf_reg);
endmodule

// *** core/dasu_digit_adder.sv ***
`timescale 1ns/1ps
`include "dasu_consts.svh"
module dasu_digit_adder import dasu_pkg::*; (
	input wire dasu_digit_t a, // Augend digit
	input wire dasu_digit_t b, // Addend digit
	input wire logic sub, // Nines-complement b
	input wire logic cin, // Carry in
	output dasu_digit_t s, // Sum digit
	output logic cout // Carry out
);
	logic [3:0] b_eff;
	logic [4:0] raw;

	// One decimal position; complement plus carry-in gives subtraction
	assign b_eff = sub ? 4'(`DASU_DIGIT_MAX - b) : b;
	assign raw = {1'b0, a} + {1'b0, b_eff} + {4'h0, cin};
	assign cout = raw >= `DASU_RADIX;
	assign s = cout ? 4'(raw - `DASU_RADIX) : raw[3:0];
endmodule

// *** core/dasu_pkg.sv ***
package dasu_pkg;
	typedef logic [3:0] dasu_digit_t;
	typedef logic [5:0] dasu_char_t;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RD_WAIT,
		ST_RD_CAP,
		ST_ADD,
		ST_RECOMP,
		ST_WR,
		ST_SETTLE
	} dasu_state_e;
endpackage

// *** testbench/dasu_mem_model.sv ***
`timescale 1ns/1ps
module dasu_mem_model (
	input wire logic CLK, // Clock
	input wire logic MEM_RD, // Read strobe
	input wire logic MEM_WR, // Write strobe
	input wire logic [14:0] MEM_ADDR, // Char address
	input wire logic [5:0] MEM_WDATA, // Char to store
	output logic [5:0] MEM_RDATA // Char read, one cycle late
);
	logic [5:0] mem_reg [0:63];

	initial MEM_RDATA = 6'h00;

	// Answer a read one cycle late; otherwise the line toggles every cycle
	// so a sample taken one cycle too late reads the data inverted
	always @(posedge CLK) begin
		if (MEM_RD) begin
			MEM_RDATA <= mem_reg[MEM_ADDR[5:0]];
		end else begin
			MEM_RDATA <= ~MEM_RDATA;
		end
		if (MEM_WR) begin
			mem_reg[MEM_ADDR[5:0]] <= MEM_WDATA;
		end
	end

	// Excess-3 digits downward from base, minus zone on the low digit only
	task automatic load_field(input int base, input int n,
		input logic [63:0] d, input logic neg);
		for (int i = 0; i < n; i++) begin
			mem_reg[base - i] = {(i == 0 && neg) ? 2'h2 : 2'h0,
				d[4*i +: 4] + 4'h3};
		end
	endtask
endmodule

// *** testbench/tb_decimal_add_subtract_unit.sv ***
`timescale 1ns/1ps
`include "dasu_consts.svh"
module tb_decimal_add_subtract_unit;
	logic CLK = 1'b0;
	logic RST = 1'b1;
	logic OP_START = 1'b0;
	logic [5:0] OP_CODE = 6'h00;
	logic [14:0] OP_ADDR = 15'h0014;
	logic [4:0] OP_LEN = 5'h01;
	logic [63:0] SEL_ACC_DIGITS_IN = 64'h0;
	logic [4:0] SEL_ACC_LEN_IN = 5'h01;
	logic SEL_ACC_SIGN_IN = 1'b0;
	logic OVF_CLR = 1'b0;
	logic [5:0] MEM_RDATA;
	logic BUSY, DONE, ILLEGAL_OP, MEM_RD, MEM_WR, SEL_ACC_WE;
	logic [14:0] MEM_ADDR;
	logic [5:0] MEM_WDATA;
	logic [63:0] SEL_ACC_DIGITS;
	logic [4:0] SEL_ACC_LEN;
	logic SEL_ACC_SIGN, ZERO_RESULT_FLAG, MINUS_RESULT_FLAG;
	logic DECIMAL_OVERFLOW_FLAG;
	logic we_seen;
	int done_cyc;
	int mismatches = 0;
	int cmp_count = 0;

	// 200 MHz
	always #2.5 CLK = ~CLK;

	// One cycle per half time unit, so instruction times can be counted
	dasu_core #(.HALF_UNIT_CYCLES(1)) dut (.CLK(CLK), .RST(RST),
		.OP_START(OP_START), .OP_CODE(OP_CODE), .OP_ADDR(OP_ADDR),
		.OP_LEN(OP_LEN), .SEL_ACC_DIGITS_IN(SEL_ACC_DIGITS_IN),
		.SEL_ACC_LEN_IN(SEL_ACC_LEN_IN), .SEL_ACC_SIGN_IN(SEL_ACC_SIGN_IN),
		.MEM_RDATA(MEM_RDATA), .OVF_CLR(OVF_CLR), .BUSY(BUSY), .DONE(DONE),
		.ILLEGAL_OP(ILLEGAL_OP), .MEM_RD(MEM_RD), .MEM_WR(MEM_WR),
		.MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .SEL_ACC_WE(SEL_ACC_WE),
		.SEL_ACC_DIGITS(SEL_ACC_DIGITS), .SEL_ACC_LEN(SEL_ACC_LEN),
		.SEL_ACC_SIGN(SEL_ACC_SIGN), .ZERO_RESULT_FLAG(ZERO_RESULT_FLAG),
		.MINUS_RESULT_FLAG(MINUS_RESULT_FLAG),
		.DECIMAL_OVERFLOW_FLAG(DECIMAL_OVERFLOW_FLAG));

	dasu_mem_model m (.CLK(CLK), .MEM_RD(MEM_RD), .MEM_WR(MEM_WR),
		.MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .MEM_RDATA(MEM_RDATA));

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Memory field at the fixed operand address, decoded back to BCD
	function automatic logic [63:0] mem_val(input int n);
		logic [63:0] v = 64'h0;
		for (int i = 0; i < n; i++) begin
			v[4*i +: 4] = m.mem_reg[20 - i][3:0] - 4'h3;
		end
		return v;
	endfunction

	// One operation; waits for DONE under a bound, stops on the DONE cycle
	task automatic run_op(input logic [5:0] code, input logic [4:0] len,
		input logic [63:0] ad, input logic [4:0] al, input logic neg);
		int n = 0;
		@(negedge CLK);
		OP_START = 1'b1;
		OP_CODE = code;
		OP_LEN = len;
		SEL_ACC_DIGITS_IN = ad;
		SEL_ACC_LEN_IN = al;
		SEL_ACC_SIGN_IN = neg;
		@(negedge CLK);
		OP_START = 1'b0;
		while (DONE !== 1'b1 && n < 2000) begin
			@(negedge CLK);
			n++;
		end
		chk(DONE, 1'b1);
		we_seen = SEL_ACC_WE;
		done_cyc = n;
	endtask

	task automatic t_add_acc();
		m.load_field(20, 6, 64'h0037_5826, 1'b0);
		run_op(`DASU_ACCUM_DECIMAL_ADD_OP, 5'h06, 64'h0650_4226, 5'h07, 1'b0);
		chk(SEL_ACC_DIGITS, 64'h0688_0052);
		chk({we_seen, SEL_ACC_LEN}, 6'h27);
		chk({ZERO_RESULT_FLAG, MINUS_RESULT_FLAG}, 2'h0);
		chk(done_cyc, 64'(`DASU_BASE_HALF +
			`DASU_STEP_HALF * 11'h006 + 11'h001));
		run_op(`DASU_ACCUM_DECIMAL_ADD_OP, 5'h06, 64'h0435, 5'h04, 1'b0);
		chk({SEL_ACC_LEN, SEL_ACC_DIGITS}, {5'h06, 64'h0037_6261});
		m.load_field(20, 16, 64'h3725_4789_1254_3421, 1'b0);
		run_op(`DASU_ACCUM_DECIMAL_ADD_OP, 5'h10, 64'h0003_4721, 5'h05, 1'b0);
		chk(SEL_ACC_LEN, 5'h10);
		chk(SEL_ACC_DIGITS, 64'h3725_4789_1257_8142);
		$display("test add decimal done");
	endtask

	// Overflow sticks across a clean operation until cleared
	task automatic t_ovf();
		m.load_field(20, 4, 64'h3175, 1'b0);
		run_op(`DASU_ACCUM_DECIMAL_ADD_OP, 5'h04, 64'h9471, 5'h04, 1'b0);
		chk(DECIMAL_OVERFLOW_FLAG, 1'b1);
		chk(SEL_ACC_DIGITS, 64'h2646);
		m.load_field(20, 6, 64'h0000_0325, 1'b0);
		run_op(`DASU_ACCUM_DECIMAL_SUB_OP, 5'h06, 64'h0001_3496, 5'h06, 1'b0);
		chk(SEL_ACC_DIGITS, 64'h0001_3171);
		chk(DECIMAL_OVERFLOW_FLAG, 1'b1);
		OVF_CLR = 1'b1;
		@(negedge CLK);
		OVF_CLR = 1'b0;
		chk(DECIMAL_OVERFLOW_FLAG, 1'b0);
		m.load_field(20, 1, 64'h1, 1'b0);
		run_op(`DASU_ACCUM_DECIMAL_SUB_OP, 5'h01, 64'h9, 5'h01, 1'b1);
		chk({DECIMAL_OVERFLOW_FLAG, MINUS_RESULT_FLAG}, 2'h3);
		chk(SEL_ACC_DIGITS, 64'h0);
		OVF_CLR = 1'b1;
		@(negedge CLK);
		OVF_CLR = 1'b0;
		$display("test overflow done");
	endtask

	task automatic t_signs();
		m.load_field(20, 1, 64'h5, 1'b0);
		run_op(`DASU_ACCUM_DECIMAL_SUB_OP, 5'h01, 64'h5, 5'h01, 1'b0);
		chk({ZERO_RESULT_FLAG, MINUS_RESULT_FLAG, SEL_ACC_SIGN}, 3'h4);
		run_op(`DASU_ACCUM_DECIMAL_SUB_OP, 5'h01, 64'h3, 5'h01, 1'b0);
		chk({SEL_ACC_DIGITS[3:0], MINUS_RESULT_FLAG}, 5'h05);
		chk(done_cyc, 64'(`DASU_BASE_HALF +
			`DASU_RCAD_HALF + 11'h001));
		m.load_field(20, 1, 64'h0, 1'b1);
		run_op(`DASU_ACCUM_DECIMAL_ADD_OP, 5'h01, 64'h0, 5'h01, 1'b1);
		chk({ZERO_RESULT_FLAG, MINUS_RESULT_FLAG, SEL_ACC_SIGN}, 3'h7);
		$display("test signs done");
	endtask

	task automatic t_mem();
		m.load_field(20, 6, 64'h0056_3048, 1'b0);
		run_op(`DASU_MEMORY_DECIMAL_ADD_OP, 5'h06, 64'h9999_9999_9999_9014,
			5'h03, 1'b0);
		chk(mem_val(6), 64'h0056_3062);
		chk(we_seen, 1'b0);
		chk(SEL_ACC_SIGN, 1'b1);
		chk(done_cyc, 64'(`DASU_BASE_HALF +
			`DASU_STEP_HALF * 11'h006 + 11'h001));
		m.load_field(20, 2, 64'h12, 1'b0);
		run_op(`DASU_MEMORY_DECIMAL_ADD_OP, 5'h02, 64'h0905, 5'h03, 1'b0);
		chk(DECIMAL_OVERFLOW_FLAG, 1'b0);
		chk(mem_val(2), 64'h17);
		m.load_field(20, 5, 64'h0008_7947, 1'b0);
		run_op(`DASU_MEMORY_DECIMAL_SUB_OP, 5'h05, 64'h0004_0263, 5'h05, 1'b0);
		chk(mem_val(5), 64'h0004_7684);
		m.load_field(20, 1, 64'h3, 1'b0);
		run_op(`DASU_MEMORY_DECIMAL_SUB_OP, 5'h01, 64'h5, 5'h01, 1'b0);
		chk({m.mem_reg[20], MINUS_RESULT_FLAG}, 7'h4b);
		chk(done_cyc, 64'(`DASU_BASE_HALF +
			`DASU_RCAM_HALF + 11'h001));
		m.load_field(20, 5, 64'h0009_4234, 1'b0);
		run_op(`DASU_MEMORY_DECIMAL_SUB_OP, 5'h05, 64'h7734, 5'h04, 1'b1);
		chk(DECIMAL_OVERFLOW_FLAG, 1'b1);
		chk(mem_val(5), 64'h1968);
		$display("test memory ops done");
	endtask

	// Each unassigned code pulses ILLEGAL_OP and never starts
	task automatic t_illegal();
		logic [5:0] codes [5] = '{`DASU_UNASSIGNED_A, `DASU_UNASSIGNED_B,
			`DASU_UNASSIGNED_C, `DASU_UNASSIGNED_D, `DASU_UNASSIGNED_E};
		foreach (codes[i]) begin
			@(negedge CLK);
			OP_START = 1'b1;
			OP_CODE = codes[i];
			@(negedge CLK);
			OP_START = 1'b0;
			chk({ILLEGAL_OP, BUSY}, 2'h2);
			@(negedge CLK);
			chk({BUSY, MEM_RD}, 2'h0);
		end
		// A valid code with L of zero is refused without a pulse
		@(negedge CLK);
		OP_START = 1'b1;
		OP_CODE = `DASU_ACCUM_DECIMAL_ADD_OP;
		OP_LEN = 5'h00;
		@(negedge CLK);
		OP_START = 1'b0;
		chk({ILLEGAL_OP, BUSY, MEM_RD}, 3'h0);
		$display("test unassigned codes done");
	endtask

	initial begin
		repeat (3) @(negedge CLK);
		RST = 1'b0;
		t_add_acc();
		t_ovf();
		t_signs();
		t_mem();
		t_illegal();
		tally_and_finish();
	end

	// Watchdog well past the expected run length
	initial begin
		#200000;
		mismatches++;
		tally_and_finish();
	end
endmodule
